// ==== core/spme_params.svh ====
// Function
// RQ1: data pin bidirectional, clock pin input only
// RQ2: program mode allows memory write and readback
// RQ3: programmer holds clock, data low before high voltage
// RQ4: low-voltage entry only when enable bit one
// RQ5: programmer drives clear low, shifts 32-bit key
// RQ6: program mode held only while clear low (code holds high-voltage mode while high voltage stays, whatever clear does)
// RQ7: enable bit one forces master-clear reset on
// RQ8: enable bit cleared only in high-voltage mode
// RQ9: shift key bits, enter on full match
`ifndef SPME_PARAMS_SVH
`define SPME_PARAMS_SVH
`define SPME_KEY_BITS    32
`define SPME_KEY_VALUE   32'h5A5A_C3E1
`define SPME_WORD_BITS   14
`define SPME_ADDR_BITS   8
`define SPME_CMD_BITS    6
`define SPME_CMD_LOAD    6'h02
`define SPME_CMD_READ    6'h04
`define SPME_CMD_INCR    6'h06
`define SPME_CMD_CFGWR   6'h08
`define SPME_FRAME_BITS  22
`endif

// ==== core/spme_pkg.sv ====
package spme_pkg;
  typedef enum logic [1:0] {
    SPME_IDLE  = 2'b00,
    SPME_KEY   = 2'b01,
    SPME_LVPM  = 2'b10,
    SPME_HVPM  = 2'b11
  } spme_state_type;
endpackage

// ==== core/spme_sync.sv ====
`timescale 1ns/1ps
module spme_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // spme_sync

// ==== core/spme_entry.sv ====
`timescale 1ns/1ps
`include "spme_params.svh"
module spme_entry
  import spme_pkg::*;
#(
  parameter int                    KEY_BITS = `SPME_KEY_BITS,
  parameter logic [KEY_BITS-1:0]   KEY      = `SPME_KEY_VALUE,
  parameter int                    DEPTH    = 256
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic prog_serial_clock,
  input  wire logic prog_serial_data_in,
  output logic      prog_serial_data_out,
  output logic      prog_serial_data_oe,
  input  wire logic master_clear_pin,
  input  wire logic programming_high_level,
  input  wire logic clear_disable_setting,
  output logic      low_voltage_prog_enable,
  output logic      clear_reset_enable,
  output logic      prog_mode,
  output logic      hv_mode,
  output logic      device_reset
);
  logic [4:0] sy;
  logic       clk_s, dat_s, clr_lo_s, clr_hi_s, hv_s, dis_s;
  logic       frame_done, read_cmd;
  logic       clk_d_r;
  logic       rise;
  spme_state_type state_r;
  logic [KEY_BITS-1:0] key_sh_r;
  logic [5:0]          key_cnt_r;
  logic [`SPME_FRAME_BITS-1:0] fr_r;
  logic [4:0]                  fr_cnt_r;
  logic [`SPME_ADDR_BITS-1:0]  addr_r;
  logic [`SPME_WORD_BITS-1:0]  mem_r [DEPTH];
  logic [`SPME_WORD_BITS-1:0]  rd_sh_r;
  logic [4:0]                  rd_cnt_r;
  logic                        lv_en_r;
  logic                        in_pm;

  // pins pass two flops; clock pin is sampled only (see RQ1)
  // clear pin enters inverted so the sync reset value is its idle level
  spme_sync #(.W(5)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       ({prog_serial_clock, prog_serial_data_in, ~master_clear_pin,
                programming_high_level, clear_disable_setting}),
    .q       (sy)
  );
  assign {clk_s, dat_s, clr_lo_s, hv_s, dis_s} = sy;
  assign clr_hi_s = ~clr_lo_s;
  assign rise  = clk_s & ~clk_d_r;
  assign in_pm = (state_r == SPME_LVPM) || (state_r == SPME_HVPM);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) clk_d_r <= 1'b0;
    else        clk_d_r <= clk_s;
  end

  // entry state machine
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r <= SPME_IDLE;
    end else begin
      case (state_r)
        SPME_IDLE: begin
          if (hv_s && !clk_s && !dat_s)
            state_r <= SPME_HVPM;
          else if (clr_lo_s && lv_en_r)    // see RQ4
            state_r <= SPME_KEY;
        end
        SPME_KEY: begin
          if (clr_hi_s || !lv_en_r)
            state_r <= SPME_IDLE;
          else if (key_cnt_r == 6'(KEY_BITS))
            state_r <= (key_sh_r == KEY) ? SPME_LVPM : SPME_IDLE;  // see RQ9
        end
        SPME_LVPM: if (clr_hi_s) state_r <= SPME_IDLE;  // see RQ6
        SPME_HVPM: if (!hv_s) state_r <= SPME_IDLE;
        default:   state_r <= SPME_IDLE;
      endcase
    end
  end

  // key shift register, msb first on each clock rise
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      key_sh_r  <= '0;
      key_cnt_r <= '0;
    end else if (state_r != SPME_KEY) begin
      key_sh_r  <= '0;
      key_cnt_r <= '0;
    end else if (rise && key_cnt_r != 6'(KEY_BITS)) begin
      key_sh_r  <= {key_sh_r[KEY_BITS-2:0], dat_s};  // see RQ9
      key_cnt_r <= key_cnt_r + 6'h01;
    end
  end

  // command frame: 6-bit command then 14-bit data then 2 pad bits; a read frame ends after its 6-bit command
  logic [`SPME_CMD_BITS-1:0] cmd_w;
  // decoded at the last rise, one place down: last pad bit not yet in
  assign cmd_w = fr_r[`SPME_FRAME_BITS-2 -: `SPME_CMD_BITS];
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !in_pm) begin
      fr_r     <= '0;
      fr_cnt_r <= '0;
    end else if (rise && rd_cnt_r == 5'h00) begin
      fr_r     <= {fr_r[`SPME_FRAME_BITS-2:0], dat_s};
      fr_cnt_r <= read_cmd ? 5'h00 :
                  (fr_cnt_r == 5'(`SPME_FRAME_BITS - 1)) ? 5'h00 : fr_cnt_r + 5'h01;
    end
  end

  assign frame_done = in_pm && rise && rd_cnt_r == 5'h00 &&
                      fr_cnt_r == 5'(`SPME_FRAME_BITS - 1);
  assign read_cmd   = in_pm && rise && rd_cnt_r == 5'h00 &&
                      fr_cnt_r == 5'(`SPME_CMD_BITS - 1) &&
                      {fr_r[4:0], dat_s} == `SPME_CMD_READ;

  // memory, address and low-voltage enable bit
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      addr_r <= '0;
    end else if (!in_pm) begin
      addr_r <= '0;
    end else if (frame_done && cmd_w == `SPME_CMD_INCR) begin
      addr_r <= addr_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
    end else if (frame_done && cmd_w == `SPME_CMD_LOAD) begin
      mem_r[addr_r] <= fr_r[`SPME_WORD_BITS:1];  // see RQ2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lv_en_r <= 1'b1;
    end else if (frame_done && cmd_w == `SPME_CMD_CFGWR) begin
      if (fr_r[1] || state_r == SPME_HVPM)
        lv_en_r <= fr_r[1];  // see RQ8
    end
  end

  // readback drives data line for 14 clock rises
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !in_pm) begin
      rd_sh_r  <= '0;
      rd_cnt_r <= '0;
    end else if (read_cmd) begin
      rd_sh_r  <= mem_r[addr_r];  // see RQ2
      rd_cnt_r <= 5'(`SPME_WORD_BITS);
    end else if (rise && rd_cnt_r != 5'h00) begin
      rd_sh_r  <= {rd_sh_r[`SPME_WORD_BITS-2:0], 1'b0};
      rd_cnt_r <= rd_cnt_r - 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prog_serial_data_out    <= 1'b0;
      prog_serial_data_oe     <= 1'b0;
      low_voltage_prog_enable <= 1'b1;
      clear_reset_enable      <= 1'b1;
      prog_mode               <= 1'b0;
      hv_mode                 <= 1'b0;
      device_reset            <= 1'b1;
    end else begin
      prog_serial_data_out    <= rd_sh_r[`SPME_WORD_BITS-1];
      prog_serial_data_oe     <= rd_cnt_r != 5'h00;  // see RQ1
      low_voltage_prog_enable <= lv_en_r;
      clear_reset_enable      <= lv_en_r | ~dis_s;  // see RQ7
      prog_mode               <= in_pm;
      hv_mode                 <= state_r == SPME_HVPM;
      device_reset            <= in_pm | (clr_lo_s & (lv_en_r | ~dis_s));
    end
  end

  // low-voltage program mode ends within a few cycles once clear is released
  property p_lv_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == SPME_LVPM && clr_hi_s) |=> state_r == SPME_IDLE;
  endproperty
  a_lv_hold: assert property (p_lv_hold) else $error("lv mode held with clear high"); // see RQ6

  property p_lv_gate;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == SPME_IDLE && !lv_en_r && !hv_s) |=> state_r != SPME_KEY;
  endproperty
  a_lv_gate: assert property (p_lv_gate) else $error("key entry while disabled"); // see RQ4

  property p_clear_forced;
    @(posedge sys_clk) disable iff (!rst_b)
      lv_en_r |=> clear_reset_enable;
  endproperty
  a_clear_forced: assert property (p_clear_forced) else $error("clear reset off"); // see RQ7

  property p_lv_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (lv_en_r && state_r != SPME_HVPM) |=> lv_en_r;
  endproperty
  a_lv_clear: assert property (p_lv_clear) else $error("lv enable cleared outside hv"); // see RQ8

  property p_key_match;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == SPME_KEY && $changed(state_r) == 0 && key_cnt_r == 6'(KEY_BITS)
       && key_sh_r != KEY && clr_lo_s) |=> state_r == SPME_IDLE;
  endproperty
  a_key_match: assert property (p_key_match) else $error("bad key accepted"); // see RQ9

  property p_oe_read;
    @(posedge sys_clk) disable iff (!rst_b)
      prog_serial_data_oe |-> $past(in_pm, 2);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("data driven outside mode"); // see RQ1

  property p_mode_out;
    @(posedge sys_clk) disable iff (!rst_b)
      in_pm |=> prog_mode;
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode output lags"); // see RQ2

  property p_key_count;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_r == SPME_KEY && rise && key_cnt_r < 6'(KEY_BITS) && clr_lo_s && lv_en_r)
      |=> key_cnt_r == $past(key_cnt_r) + 6'h01;
  endproperty
  a_key_count: assert property (p_key_count) else $error("key bit not counted"); // see RQ9
endmodule // spme_entry

// ==== tb/spme_programmer.sv ====
`timescale 1ns/1ps
module spme_programmer (
  input  wire logic sys_clk,
  input  wire logic dat_in,
  output logic      pclk,
  output logic      pdat,
  output logic      clr,
  output logic      hvl
);
  initial begin
    pclk = 1'b0;
    pdat = 1'b0;
    clr  = 1'b1;
    hvl  = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // msb first, clock stands low outside frames
  task automatic send(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      pdat = v[i];
      wt(4);
      pclk = 1'b1;
      wt(8);
      pclk = 1'b0;
      wt(4);
    end
    pdat = ~pdat;
  endtask
  task automatic recv(output logic [13:0] w);
    for (int i = 13; i >= 0; i--) begin
      wt(4);
      // bit stands before the rise that moves the device on
      w[i] = dat_in;
      pclk = 1'b1;
      wt(8);
      pclk = 1'b0;
      wt(4);
    end
  endtask
  task automatic lv_enter(input logic [31:0] key);
    clr  = 1'b0;
    wt(4);
    send(key, 32);
    wt(8);
  endtask
  task automatic hv_enter();
    pclk = 1'b0;
    pdat = 1'b0;
    wt(4);
    hvl = 1'b1;
    wt(8);
  endtask
  task automatic leave();
    clr  = 1'b1;
    hvl  = 1'b0;
    wt(8);
  endtask
endmodule // spme_programmer

// ==== tb/serial_program_mode_entry_tb.sv ====
`timescale 1ns/1ps
`include "spme_params.svh"
module serial_program_mode_entry_tb;
  logic        sys_clk, rst_b, mdis, pclk, pdat, clr, hvl, dat_w;
  logic        dout, doe, lv_en, mre, pm, hv, drst;
  logic [13:0] rd;
  int          error_cnt = 0;
  int          checks_done = 0;
  assign dat_w = doe ? dout : pdat;
  spme_entry uut (.sys_clk(sys_clk), .rst_b(rst_b), .prog_serial_clock(pclk),
    .prog_serial_data_in(dat_w), .prog_serial_data_out(dout), .prog_serial_data_oe(doe),
    .master_clear_pin(clr), .programming_high_level(hvl), .clear_disable_setting(mdis),
    .low_voltage_prog_enable(lv_en), .clear_reset_enable(mre), .prog_mode(pm),
    .hv_mode(hv), .device_reset(drst));
  spme_programmer prg (.sys_clk(sys_clk), .dat_in(dat_w), .pclk(pclk), .pdat(pdat),
    .clr(clr), .hvl(hvl));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [13:0] got, input logic [13:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk({doe, lv_en, mre, pm, hv, drst}, 14'h18, "reset values");
  endtask
  task automatic t_lv_key();
    prg.lv_enter(~`SPME_KEY_VALUE);
    chk(pm, 1'b0, "wrong key");
    prg.leave();
    prg.lv_enter(`SPME_KEY_VALUE);
    chk(pm, 1'b1, "key entry");
    chk(mre, 1'b1, "clear forced on");
    chk(drst, 1'b1, "core held in reset");
  endtask
  task automatic t_lv_data();
    prg.send({`SPME_CMD_LOAD, 14'h2A5, 2'b00}, 22);
    prg.send({26'h0, `SPME_CMD_READ}, 6);
    prg.recv(rd);
    chk(rd, 14'h2A5, "readback");
    chk(doe, 1'b0, "pin released");
    prg.send({`SPME_CMD_INCR, 16'h0}, 22);
    prg.send({26'h0, `SPME_CMD_READ}, 6);
    prg.recv(rd);
    chk(rd, 14'h0, "next address");
    prg.send({`SPME_CMD_CFGWR, 14'h0, 2'b00}, 22);
    chk(lv_en, 1'b1, "lv clear refused");
    prg.leave();
    chk(pm, 1'b0, "exit on clear high");
  endtask
  task automatic t_hv();
    prg.hv_enter();
    chk({pm, hv}, 2'b11, "hv entry");
    prg.send({`SPME_CMD_CFGWR, 14'h0, 2'b00}, 22);
    chk(lv_en, 1'b0, "hv clear taken");
    chk(mre, 1'b0, "clear disable obeyed");
    prg.leave();
    prg.lv_enter(`SPME_KEY_VALUE);
    chk(pm, 1'b0, "lv entry refused");
    prg.leave();
    mdis = 1'b0;
    prg.wt(5);
    chk(mre, 1'b1, "clear enabled by setting");
  endtask
  initial begin
    rst_b = 1'b0;
    mdis  = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    t_reset();
    t_lv_key();
    t_lv_data();
    t_hv();
    report_and_stop();
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule // serial_program_mode_entry_tb
